/* File: rtl/trace_pkt_pkg.sv */
// constants, register map and types for the hardware-source trace packetizer
`default_nettype none

package trace_pkt_pkg;

    // ==========================================================
    // register offsets (byte addresses on apb)
    localparam logic [7:0]  CTRL_OFFSET     = 8'h00;
    localparam logic [7:0]  CMP_CFG_OFFSET  = 8'h04;
    localparam logic [7:0]  STATUS_OFFSET   = 8'h08;
    localparam logic [7:0]  CYCLES_OFFSET   = 8'h0c;

    // ==========================================================
    // field positions
    localparam int          CTRL_ENABLE_BIT = 0;
    localparam int          CTRL_TAP_BIT    = 1;
    localparam int          CTRL_RELOAD_LSB = 4;
    localparam int          RELOAD_WIDTH    = 4;
    localparam int          CFG_PC_BIT      = 0;
    localparam int          CFG_ADDR_BIT    = 1;
    localparam int          CFG_DATA_BIT    = 2;
    localparam int          STAT_OVF_LSB    = 0;
    localparam int          STAT_OUT_BIT    = 8;
    localparam int          STAT_PEND_BIT   = 9;
    localparam int          STAT_CNT_LSB    = 10;

    // ==========================================================
    // reset values
    localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
    localparam logic [31:0] CMP_CFG_RESET   = 32'h0000_0000;

    // ==========================================================
    // timing: tap of the cycle counter, in counter bits (log2 of cycles per tap step)
    localparam int          TAP_LOW_BITS    = 6;
    localparam int          TAP_HIGH_BITS   = 10;

    // ==========================================================
    // packet encodings
    localparam logic [4:0]  DISC_PC_SAMPLE  = 5'h02;
    localparam logic [1:0]  TYPE_PC_ADDR    = 2'h1;
    localparam logic [1:0]  TYPE_DATA       = 2'h2;
    localparam logic [1:0]  SS_ONE          = 2'h1;
    localparam logic [1:0]  SS_TWO          = 2'h2;
    localparam logic [1:0]  SS_FOUR         = 2'h3;
    localparam logic [7:0]  OVERFLOW_HEADER = 8'h70;
    localparam logic [1:0]  SIZE_BYTE       = 2'h0;
    localparam logic [1:0]  SIZE_HALF       = 2'h1;

    typedef enum logic [2:0] {
        LD_NONE,
        LD_PEND,
        LD_OVF,
        LD_CMP,
        LD_SAMP
    } load_sel_t;

endpackage : trace_pkt_pkg

`default_nettype wire

/* File: rtl/pc_sample_data_trace_packetizer.sv */
// hardware-source packet builder: periodic pc samples and comparator data trace
//
// Overview of operation
// - pc samples at fixed intervals, cycle accurate
// - interval from down counter, tap-selected cycle counter
// - sample packets only while sampling enabled
// - full four-byte sample, one-byte sleep packet
// - sample discriminator 2; size 11 or 01
// - full payload is pc, low byte first
// - sleep payload byte is zero
// - data trace only on configured comparator match
// - only comparators 0 to 3 trace data
// - one or two packet outputs per match
// - type bits 01 or 10, never others
// - header bits 5:4 hold comparator index
// - bit 3: pc zero, address one
// - data value bit 3 is write flag
// - pc packet carries matching instruction address
// - address packet carries low sixteen bits
// - data size follows transfer size
// - data value bytes lowest first
// - header bit 2 one, except in overflow packet
// - full output gives overflow packet instead
// - size codes map one, two, four bytes
`default_nettype none

module pc_sample_data_trace_packetizer (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [31:0] cpu_pc,
    input  wire logic        cpu_sleeping,
    input  wire logic        cmp_match,
    input  wire logic [2:0]  cmp_index,
    input  wire logic [31:0] cmp_pc,
    input  wire logic [15:0] cmp_addr_low,
    input  wire logic [31:0] cmp_data,
    input  wire logic [1:0]  cmp_size,
    input  wire logic        cmp_write,
    output logic             pkt_valid,
    input  wire logic        pkt_ready,
    output logic      [7:0]  pkt_header,
    output logic      [31:0] pkt_payload
);

    // ==========================================================
    // helpers
    function automatic logic [7:0] hdr(input logic [4:0] disc, input logic [1:0] ss);
        return {disc, 1'b1, ss};
    endfunction : hdr

    function automatic logic [1:0] ss_of(input logic [1:0] size);
        if (size == trace_pkt_pkg::SIZE_BYTE) begin
            return trace_pkt_pkg::SS_ONE;
        end else if (size == trace_pkt_pkg::SIZE_HALF) begin
            return trace_pkt_pkg::SS_TWO;
        end
        return trace_pkt_pkg::SS_FOUR;
    endfunction : ss_of

    function automatic logic [31:0] mask_of(input logic [1:0] size);
        if (size == trace_pkt_pkg::SIZE_BYTE) begin
            return 32'h0000_00ff;
        end else if (size == trace_pkt_pkg::SIZE_HALF) begin
            return 32'h0000_ffff;
        end
        return 32'hffff_ffff;
    endfunction : mask_of

    // ==========================================================
    // declarations
    logic [31:0]                     ctrl;
    logic [31:0]                     cmp_cfg;
    logic [31:0]                     processor_cycle_counter;
    logic [3:0]                      sample_interval_counter;
    logic [7:0]                      overflow_count;
    logic                            pend_valid;
    logic [7:0]                      pend_header;
    logic [31:0]                     pend_payload;
    logic                            ovf_pend;
    logic                            pc_sampling_enable;
    logic                            interval_tap_select;
    logic [3:0]                      reload_value;
    logic                            tap_pulse;
    logic                            samp_ev;
    logic                            cmp_ev;
    logic [2:0]                      cfg_sel;
    logic                            emit_address_enable;
    logic [7:0]                      data_header;
    logic [31:0]                     data_payload;
    logic [7:0]                      first_header;
    logic [31:0]                     first_payload;
    logic                            first_pend;
    logic [7:0]                      samp_header;
    logic [31:0]                     samp_payload;
    logic                            slot_free;
    logic                            lost;
    trace_pkt_pkg::load_sel_t        load_sel;
    logic                            apb_write;
    logic                            apb_setup;
    logic                            mapped;

    assign pc_sampling_enable  = ctrl[trace_pkt_pkg::CTRL_ENABLE_BIT];
    assign interval_tap_select = ctrl[trace_pkt_pkg::CTRL_TAP_BIT];
    assign reload_value        = ctrl[trace_pkt_pkg::CTRL_RELOAD_LSB +:
                                      trace_pkt_pkg::RELOAD_WIDTH];

    // ==========================================================
    // apb slave: zero wait states, read data latched in setup
    assign apb_setup = psel && !penable;
    assign apb_write = psel && penable && pwrite;
    assign pready    = 1'b1;
    assign mapped    = (paddr == trace_pkt_pkg::CTRL_OFFSET) ||
                       (paddr == trace_pkt_pkg::CMP_CFG_OFFSET) ||
                       (paddr == trace_pkt_pkg::STATUS_OFFSET) ||
                       (paddr == trace_pkt_pkg::CYCLES_OFFSET);
    assign pslverr   = psel && penable && !mapped;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ctrl    <= trace_pkt_pkg::CTRL_RESET;
            cmp_cfg <= trace_pkt_pkg::CMP_CFG_RESET;
        end else if (apb_write) begin
            if (paddr == trace_pkt_pkg::CTRL_OFFSET) begin
                ctrl <= pwdata;
            end
            if (paddr == trace_pkt_pkg::CMP_CFG_OFFSET) begin
                cmp_cfg <= pwdata;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            prdata <= 32'h0000_0000;
        end else if (apb_setup && !pwrite) begin
            case (paddr)
                trace_pkt_pkg::CTRL_OFFSET:    prdata <= ctrl;
                trace_pkt_pkg::CMP_CFG_OFFSET: prdata <= cmp_cfg;
                trace_pkt_pkg::STATUS_OFFSET: begin
                    prdata <= {18'h0, sample_interval_counter, pend_valid, pkt_valid,
                               overflow_count};
                end
                trace_pkt_pkg::CYCLES_OFFSET:  prdata <= processor_cycle_counter;
                default:                       prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // sample interval timing
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            processor_cycle_counter <= 32'h0000_0000;
        end else begin
            processor_cycle_counter <= processor_cycle_counter + 32'h0000_0001;
        end
    end

    // tap step lands on the cycle before the tapped bit falls
    assign tap_pulse = interval_tap_select ?
        (&processor_cycle_counter[trace_pkt_pkg::TAP_HIGH_BITS-1:0]) :
        (&processor_cycle_counter[trace_pkt_pkg::TAP_LOW_BITS-1:0]);

    assign samp_ev = pc_sampling_enable && tap_pulse &&
                     (sample_interval_counter == 4'h0);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sample_interval_counter <= 4'h0;
        end else if (!pc_sampling_enable) begin
            // held at reload so the first interval after enable runs reload+1 tap steps, the first one partial
            sample_interval_counter <= reload_value;
        end else if (tap_pulse) begin
            if (sample_interval_counter == 4'h0) begin
                sample_interval_counter <= reload_value;
            end else begin
                sample_interval_counter <= sample_interval_counter - 4'h1;
            end
        end
    end

    // ==========================================================
    // packet formation and output slot selection
    always_comb begin
        cfg_sel             = cmp_cfg[{cmp_index[1:0], 2'b00} +: 3];
        emit_address_enable = cfg_sel[trace_pkt_pkg::CFG_ADDR_BIT];
        cmp_ev              = cmp_match && !cmp_index[2] && (|cfg_sel);
        data_header  = hdr({trace_pkt_pkg::TYPE_DATA, cmp_index[1:0], cmp_write},
                           ss_of(cmp_size));
        data_payload = cmp_data & mask_of(cmp_size);
        if (cfg_sel[trace_pkt_pkg::CFG_PC_BIT]) begin
            first_header  = hdr({trace_pkt_pkg::TYPE_PC_ADDR, cmp_index[1:0], 1'b0},
                                trace_pkt_pkg::SS_FOUR);
            first_payload = cmp_pc;
        end else if (emit_address_enable) begin
            first_header  = hdr({trace_pkt_pkg::TYPE_PC_ADDR, cmp_index[1:0], 1'b1},
                                trace_pkt_pkg::SS_TWO);
            first_payload = {16'h0000, cmp_addr_low};
        end else begin
            first_header  = data_header;
            first_payload = data_payload;
        end
        first_pend = (cfg_sel[trace_pkt_pkg::CFG_PC_BIT] || emit_address_enable) &&
                     cfg_sel[trace_pkt_pkg::CFG_DATA_BIT];
        if (cpu_sleeping) begin
            samp_header  = hdr(trace_pkt_pkg::DISC_PC_SAMPLE, trace_pkt_pkg::SS_ONE);
            samp_payload = 32'h0000_0000;
        end else begin
            samp_header  = hdr(trace_pkt_pkg::DISC_PC_SAMPLE, trace_pkt_pkg::SS_FOUR);
            samp_payload = cpu_pc;
        end
        slot_free = !pkt_valid || pkt_ready;
        // pending data value first keeps a pair back to back
        if (!slot_free) begin
            load_sel = trace_pkt_pkg::LD_NONE;
        end else if (pend_valid) begin
            load_sel = trace_pkt_pkg::LD_PEND;
        end else if (ovf_pend) begin
            load_sel = trace_pkt_pkg::LD_OVF;
        end else if (cmp_ev) begin
            load_sel = trace_pkt_pkg::LD_CMP;
        end else if (samp_ev) begin
            load_sel = trace_pkt_pkg::LD_SAMP;
        end else begin
            load_sel = trace_pkt_pkg::LD_NONE;
        end
        lost = (cmp_ev && (load_sel != trace_pkt_pkg::LD_CMP)) ||
               (samp_ev && (load_sel != trace_pkt_pkg::LD_SAMP));
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pkt_valid   <= 1'b0;
            pkt_header  <= 8'h00;
            pkt_payload <= 32'h0000_0000;
        end else begin
            case (load_sel)
                trace_pkt_pkg::LD_PEND: begin
                    pkt_valid   <= 1'b1;
                    pkt_header  <= pend_header;
                    pkt_payload <= pend_payload;
                end
                trace_pkt_pkg::LD_OVF: begin
                    pkt_valid   <= 1'b1;
                    pkt_header  <= trace_pkt_pkg::OVERFLOW_HEADER;
                    pkt_payload <= 32'h0000_0000;
                end
                trace_pkt_pkg::LD_CMP: begin
                    pkt_valid   <= 1'b1;
                    pkt_header  <= first_header;
                    pkt_payload <= first_payload;
                end
                trace_pkt_pkg::LD_SAMP: begin
                    pkt_valid   <= 1'b1;
                    pkt_header  <= samp_header;
                    pkt_payload <= samp_payload;
                end
                trace_pkt_pkg::LD_NONE: begin
                    if (pkt_ready) begin
                        pkt_valid <= 1'b0;
                    end
                end
                default: begin
                    pkt_valid <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pend_valid   <= 1'b0;
            pend_header  <= 8'h00;
            pend_payload <= 32'h0000_0000;
        end else if ((load_sel == trace_pkt_pkg::LD_CMP) && first_pend) begin
            pend_valid   <= 1'b1;
            pend_header  <= data_header;
            pend_payload <= data_payload;
        end else if (load_sel == trace_pkt_pkg::LD_PEND) begin
            pend_valid <= 1'b0;
        end
    end

    // a loss in the same cycle as the overflow load keeps the flag set
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ovf_pend       <= 1'b0;
            overflow_count <= 8'h00;
        end else begin
            if (lost) begin
                ovf_pend <= 1'b1;
            end else if (load_sel == trace_pkt_pkg::LD_OVF) begin
                ovf_pend <= 1'b0;
            end
            if (lost && (overflow_count != 8'hff)) begin
                overflow_count <= overflow_count + 8'h01;
            end
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_pair_first;
        (load_sel == trace_pkt_pkg::LD_CMP) && first_pend;
    endsequence

    sequence s_pair_taken;
        s_pair_first ##1 pkt_ready;
    endsequence

    property p_samp_only_enabled;
        (load_sel == trace_pkt_pkg::LD_SAMP) |-> pc_sampling_enable && tap_pulse;
    endproperty
    a_samp_only_enabled: assert property (p_samp_only_enabled)
        else $error("sample packet loaded while sampling disabled");

    property p_full_sample;
        (load_sel == trace_pkt_pkg::LD_SAMP) && !cpu_sleeping |=>
            pkt_valid && (pkt_header == 8'h17) && (pkt_payload == $past(cpu_pc));
    endproperty
    a_full_sample: assert property (p_full_sample)
        else $error("full sample packet malformed");

    property p_sleep_sample;
        (load_sel == trace_pkt_pkg::LD_SAMP) && cpu_sleeping |=>
            pkt_valid && (pkt_header == 8'h15) && (pkt_payload == 32'h0000_0000);
    endproperty
    a_sleep_sample: assert property (p_sleep_sample)
        else $error("sleep sample packet malformed");

    property p_high_cmp_silent;
        cmp_match && cmp_index[2] && slot_free && !pend_valid && !ovf_pend && !samp_ev |=>
            !pkt_valid;
    endproperty
    a_high_cmp_silent: assert property (p_high_cmp_silent)
        else $error("comparator above 3 produced data trace");

    property p_pair_second;
        s_pair_taken |=> pkt_valid && (pkt_header[7:6] == 2'h2) &&
            (pkt_header[5:4] == $past(pkt_header[5:4], 1));
    endproperty
    a_pair_second: assert property (p_pair_second)
        else $error("data value did not follow paired packet");

    property p_hw_source_bit;
        pkt_valid && (pkt_header != trace_pkt_pkg::OVERFLOW_HEADER) |-> pkt_header[2];
    endproperty
    a_hw_source_bit: assert property (p_hw_source_bit)
        else $error("header bit 2 clear");

    property p_type_legal;
        pkt_valid && (pkt_header[7:3] >= 5'h08) |->
            (pkt_header[7:6] == 2'h1) || (pkt_header[7:6] == 2'h2);
    endproperty
    a_type_legal: assert property (p_type_legal)
        else $error("reserved data trace type emitted");

    property p_lost_overflow;
        lost |=> ovf_pend && (overflow_count != 8'h00);
    endproperty
    a_lost_overflow: assert property (p_lost_overflow)
        else $error("lost packet without overflow");

    property p_reload;
        samp_ev |=> sample_interval_counter == $past(reload_value);
    endproperty
    a_reload: assert property (p_reload)
        else $error("interval counter did not reload");

    property p_byte_value;
        (load_sel == trace_pkt_pkg::LD_CMP) && (first_header[7:6] == 2'h2) &&
            (cmp_size == trace_pkt_pkg::SIZE_BYTE) |=>
            (pkt_header[1:0] == 2'h1) && (pkt_payload[31:8] == 24'h000000);
    endproperty
    a_byte_value: assert property (p_byte_value)
        else $error("byte data value size wrong");

    property p_hold;
        pkt_valid && !pkt_ready |=> pkt_valid && $stable(pkt_header) && $stable(pkt_payload);
    endproperty
    a_hold: assert property (p_hold)
        else $error("packet changed while stalled");

endmodule : pc_sample_data_trace_packetizer

`default_nettype wire

/* File: tb/trace_mux_model.sv */
// stand-in for the trace output mux: takes packets, may stall, logs them
`default_nettype none

module trace_mux_model (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        stall,
    input  wire logic        pkt_valid,
    output logic             pkt_ready,
    input  wire logic [7:0]  pkt_header,
    input  wire logic [31:0] pkt_payload
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0]  hq[$];
    logic [31:0] pq[$];
    time         tq[$];

    // ==========================================================
    // acceptance
    // level ready; a stall leaves the packet standing in the block's slot
    assign pkt_ready = !stall;

    always @(posedge clk) begin
        if (reset_n && pkt_valid && pkt_ready) begin
            hq.push_back(pkt_header);
            pq.push_back(pkt_payload);
            tq.push_back($time);
        end
    end
endmodule : trace_mux_model

`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench for the pc sample and data trace packetizer
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [31:0] cpu_pc = 32'h0000_1234;
    logic        cpu_sleeping = 1'b0;
    logic        cmp_match = 1'b0;
    logic [2:0]  cmp_index = 3'h0;
    logic [31:0] cmp_pc = 32'h0;
    logic [15:0] cmp_addr_low = 16'h0;
    logic [31:0] cmp_data = 32'h0;
    logic [1:0]  cmp_size = 2'h0;
    logic        cmp_write = 1'b0;
    logic        pkt_valid;
    logic        pkt_ready;
    logic [7:0]  pkt_header;
    logic [31:0] pkt_payload;
    logic        stall = 1'b0;
    int          num_errors = 0;
    int          num_checks = 0;
    logic [7:0]  h;
    logic [31:0] p;
    logic [31:0] rd;
    logic        err;
    time         t1;
    time         t2;

    always #5 clk = ~clk;

    pc_sample_data_trace_packetizer u_dut (.clk(clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cpu_pc(cpu_pc), .cpu_sleeping(cpu_sleeping),
        .cmp_match(cmp_match), .cmp_index(cmp_index), .cmp_pc(cmp_pc),
        .cmp_addr_low(cmp_addr_low), .cmp_data(cmp_data), .cmp_size(cmp_size),
        .cmp_write(cmp_write), .pkt_valid(pkt_valid), .pkt_ready(pkt_ready),
        .pkt_header(pkt_header), .pkt_payload(pkt_payload));

    trace_mux_model u_mux (.clk(clk), .reset_n(reset_n), .stall(stall),
        .pkt_valid(pkt_valid), .pkt_ready(pkt_ready), .pkt_header(pkt_header),
        .pkt_payload(pkt_payload));

    // ==========================================================
    // reporting
    task automatic give_verdict();
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : give_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // ==========================================================
    // apb master: setup, then access held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (!(pready === 1'b1) && n < 50);
        if (n == 50) begin
            num_errors++;
            give_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    // ==========================================================
    // comparator stimulus and packet collection
    task automatic fire(input logic [2:0] i, input logic [31:0] pc, input logic [15:0] a,
                        input logic [31:0] d, input logic [1:0] s, input logic w);
        cmp_match <= 1'b1;
        cmp_index <= i;
        cmp_pc <= pc;
        cmp_addr_low <= a;
        cmp_data <= d;
        cmp_size <= s;
        cmp_write <= w;
        @(posedge clk);
        cmp_match <= 1'b0;
        cmp_data <= ~d;
        @(posedge clk);
    endtask : fire

    task automatic get_pkt();
        int n;
        n = 0;
        while (u_mux.hq.size() == 0 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        if (n == 3000) begin
            num_errors++;
            give_verdict();
        end
        h = u_mux.hq.pop_front();
        p = u_mux.pq.pop_front();
        t1 = t2;
        t2 = u_mux.tq.pop_front();
    endtask : get_pkt

    task automatic exp_pkt(input logic [7:0] eh, input logic [31:0] ep);
        get_pkt();
        check({24'h0, h}, {24'h0, eh});
        check(p, ep);
    endtask : exp_pkt

    initial begin
        t2 = 0;
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        apb(1'b0, 8'h00, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        check({31'h0, err}, 32'h1);
        // cmp0 pc+data, cmp1 addr+data, cmp2 data, cmp3 pc, cmp4 data (never traced)
        apb(1'b1, 8'h04, 32'h0004_1465);
        apb(1'b0, 8'h04, 32'h0);
        check(rd & 32'h0000_7777, 32'h0000_1465);
        fire(3'd0, 32'h0000_0100, 16'h0, 32'h1122_3344, 2'd2, 1'b1);
        exp_pkt(8'h47, 32'h0000_0100);
        exp_pkt(8'h8f, 32'h1122_3344);
        check(32'(t2 - t1), 32'd10);
        fire(3'd1, 32'h0, 16'hbeef, 32'h0000_5566, 2'd1, 1'b0);
        exp_pkt(8'h5e, 32'h0000_beef);
        exp_pkt(8'h96, 32'h0000_5566);
        for (int s = 0; s < 4; s++) begin
            fire(3'd2, 32'h0, 16'h0, 32'ha1b2_c3d4, s[1:0], s[0]);
            exp_pkt({4'ha, s[0], 1'b1, (s == 0) ? 2'd1 : (s == 1) ? 2'd2 : 2'd3},
                    (s == 0) ? 32'hd4 : (s == 1) ? 32'hc3d4 : 32'ha1b2_c3d4);
        end
        fire(3'd3, 32'h0000_2000, 16'h0, 32'h0, 2'd0, 1'b0);
        exp_pkt(8'h77, 32'h0000_2000);
        fire(3'd4, 32'h0, 16'h0, 32'hffff_ffff, 2'd2, 1'b0);
        repeat (20) @(posedge clk);
        check(u_mux.hq.size(), 0);
        // a second event while the slot is held is lost and reported
        stall <= 1'b1;
        fire(3'd2, 32'h0, 16'h0, 32'h0000_00aa, 2'd0, 1'b0);
        fire(3'd2, 32'h0, 16'h0, 32'h0000_00bb, 2'd0, 1'b0);
        stall <= 1'b0;
        exp_pkt(8'ha5, 32'h0000_00aa);
        exp_pkt(8'h70, 32'h0);
        // status: one lost event counted, slot empty, interval counter at reload 0
        apb(1'b0, 8'h08, 32'h0);
        check(rd, 32'h0000_0001);
        // sampling: tap 0, reload 0, so one sample per 64 cycles
        apb(1'b1, 8'h00, 32'h0000_0001);
        exp_pkt(8'h17, 32'h0000_1234);
        exp_pkt(8'h17, 32'h0000_1234);
        check(32'(t2 - t1), 32'd640);
        // tap 1, reload 1: two steps of 1024 cycles per sample
        apb(1'b1, 8'h00, 32'h0000_0013);
        exp_pkt(8'h17, 32'h0000_1234);
        exp_pkt(8'h17, 32'h0000_1234);
        check(32'(t2 - t1), 32'd20480);
        cpu_sleeping <= 1'b1;
        exp_pkt(8'h15, 32'h0);
        apb(1'b1, 8'h00, 32'h0000_0000);
        repeat (2) @(posedge clk);
        u_mux.hq.delete();
        repeat (200) @(posedge clk);
        check(u_mux.hq.size(), 0);
        give_verdict();
    end
endmodule : testbench

`default_nettype wire
